//--- hdl/alias_map.sv
// Purpose: Native register files with the legacy instruction set aliased onto them
// Assumes: Classic Wishbone slave, one clock, synchronous active-low reset
// Notes: A register is written through an index, a staging word and a commit, and read through the index and the data words
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module alias_map
  import alias_map_pkg::*;
#(
  parameter logic [63:0] UNDEF_FILL = 64'hdead_beef_dead_beef
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic LEGACY_MODE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [127:0][63:0] ireg;
    logic [127:0][79:0] freg;
    logic [79:0] stage;
    logic [63:0] ip;
    logic [8:0] index;
    logic [2:0] sel_slot;
    logic legacy;
    logic refused;
    logic ack;
    logic [31:0] dat;
  } state_type;

  generate
    if (UNDEF_FILL == 64'h0) begin : g_chk
      $error("UNDEF_FILL must differ from zero so spoiled registers stay visible");
    end
  endgenerate

  state_type s_q;
  state_type s_d;

  logic hit;
  logic wr;
  logic fp;
  logic [6:0] idx;
  logic ok;
  class_type cls;
  logic [79:0] cur;
  logic [6:0] spack;
  logic [15:0] sel_cur;
  logic refuse_ev;
  logic leg_next;
  logic [31:0] m_leg;
  logic [31:0] m_idx;
  logic [31:0] m_exp;
  logic [31:0] m_slot;
  logic [31:0] m_seldat;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    hit = WB_CYC_I && WB_STB_I && !s_q.ack;
    wr = hit && WB_WE_I;
    s_d.ack = hit;
    s_d.dat = 32'h0000_0000;
    fp = s_q.index[IDX_FILE_BIT];
    idx = s_q.index[6:0];
    cls = reg_class(fp, idx);
    ok = !s_q.legacy || cls == CL_LEGACY;
    cur = fp ? s_q.freg[idx] : {16'h0000, s_q.ireg[idx]};
    spack = s_q.sel_slot[2] ? INT_SEL_CODE_PACK : INT_SEL_DATA_PACK;
    sel_cur = s_q.ireg[spack][s_q.sel_slot[1:0]*SEL_W +: SEL_W];
    refuse_ev = 1'b0;
    // Merged bus words, sliced below
    m_leg = wmerge({31'h0, s_q.legacy}, WB_DAT_I, WB_SEL_I);
    leg_next = m_leg[CTRL_LEGACY_BIT];
    m_idx = wmerge({23'h0, s_q.index}, WB_DAT_I, WB_SEL_I);
    m_exp = wmerge({16'h0, s_q.stage[79:64]}, WB_DAT_I, WB_SEL_I);
    m_slot = wmerge({29'h0, s_q.sel_slot}, WB_DAT_I, WB_SEL_I);
    m_seldat = wmerge({16'h0, sel_cur}, WB_DAT_I, WB_SEL_I);

    // --------------------------------------------------------------
    // Reads
    // --------------------------------------------------------------
    if (hit && !WB_WE_I) begin
      case (WB_ADR_I)
        A_CTRL: s_d.dat[CTRL_LEGACY_BIT] = s_q.legacy;
        A_INDEX: s_d.dat[8:0] = s_q.index;
        A_DATA_LO, A_DATA_HI, A_DATA_EXP: begin
          if (!ok) begin
            refuse_ev = 1'b1;
          end else if (WB_ADR_I == A_DATA_LO) begin
            s_d.dat = cur[31:0];
          end else if (WB_ADR_I == A_DATA_HI) begin
            s_d.dat = cur[63:32];
          end else begin
            s_d.dat[15:0] = cur[79:64];
          end
        end
        A_IP_LO: s_d.dat = s_q.ip[31:0];
        A_IP_HI: s_d.dat = s_q.ip[63:32];
        A_STATUS: begin
          s_d.dat[STAT_LEGACY_BIT] = s_q.legacy;
          s_d.dat[STAT_REFUSED_BIT] = s_q.refused;
        end
        A_SEL_SLOT: s_d.dat[2:0] = s_q.sel_slot;
        A_SEL_DATA: s_d.dat[15:0] = sel_cur;
        default: s_d.dat = 32'h0000_0000;
      endcase
    end

    // --------------------------------------------------------------
    // Writes
    // --------------------------------------------------------------
    if (wr) begin
      case (WB_ADR_I)
        A_CTRL: begin
          s_d.legacy = leg_next;
          if (s_q.legacy && !leg_next) begin
            for (int i = 0; i < 128; i++) begin
              if (reg_class(1'b0, 7'(i)) == CL_SCRATCH) s_d.ireg[i] = UNDEF_FILL;
              if (reg_class(1'b1, 7'(i)) == CL_SCRATCH) s_d.freg[i] = {16'h0000, UNDEF_FILL};
            end
          end
        end
        A_INDEX: s_d.index = m_idx[8:0];
        A_DATA_LO: s_d.stage[31:0] = wmerge(s_q.stage[31:0], WB_DAT_I, WB_SEL_I);
        A_DATA_HI: s_d.stage[63:32] = wmerge(s_q.stage[63:32], WB_DAT_I, WB_SEL_I);
        A_DATA_EXP: begin
          s_d.stage[79:64] = m_exp[15:0];
        end
        A_CMD: begin
          if (WB_SEL_I[0] && WB_DAT_I[CMD_COMMIT_BIT]) begin
            if (!ok) begin
              refuse_ev = 1'b1;
            end else if (cls == CL_CONST) begin
              refuse_ev = 1'b0;
            end else if (fp) begin
              s_d.freg[idx] = s_q.stage;
            end else if (s_q.legacy && idx >= INT_GPR_FIRST && idx <= INT_GPR_LAST) begin
              s_d.ireg[idx][LEGACY_GPR_W-1:0] = s_q.stage[LEGACY_GPR_W-1:0];
            end else begin
              s_d.ireg[idx] = s_q.stage[MANT_W-1:0];
            end
          end
        end
        A_IP_LO: s_d.ip[31:0] = wmerge(s_q.ip[31:0], WB_DAT_I, WB_SEL_I);
        A_IP_HI: s_d.ip[63:32] = wmerge(s_q.ip[63:32], WB_DAT_I, WB_SEL_I);
        A_STATUS: begin
          if (WB_SEL_I[0] && WB_DAT_I[STAT_REFUSED_BIT]) s_d.refused = 1'b0;
        end
        A_SEL_SLOT: s_d.sel_slot = m_slot[2:0];
        A_SEL_DATA: begin
          s_d.ireg[spack][s_q.sel_slot[1:0]*SEL_W +: SEL_W] = m_seldat[15:0];
        end
        default: s_d.refused = s_q.refused;
      endcase
    end

    if (refuse_ev) s_d.refused = 1'b1;

    if (!RST_N) begin
      s_d = '0;
      s_d.freg[FP_ONE] = FP_ONE_VAL;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    s_q <= s_d;
  end

  assign WB_DAT_O = s_q.dat;
  assign WB_ACK_O = s_q.ack;
  assign LEGACY_MODE = s_q.legacy;

endmodule
`default_nettype wire

//--- hdl/alias_map_pkg.sv
// Purpose: Constants and types for the dual instruction set register alias map
// Assumes: Byte-addressed Wishbone slave with 32-bit data
// Notes: Register numbers name the native integer and floating-point files
package alias_map_pkg;

  // ----------------------------------------------------------------
  // Bus register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INDEX = 8'h04;
  localparam logic [7:0] A_DATA_LO = 8'h08;
  localparam logic [7:0] A_DATA_HI = 8'h0c;
  localparam logic [7:0] A_DATA_EXP = 8'h10;
  localparam logic [7:0] A_CMD = 8'h14;
  localparam logic [7:0] A_IP_LO = 8'h18;
  localparam logic [7:0] A_IP_HI = 8'h1c;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_SEL_SLOT = 8'h24;
  localparam logic [7:0] A_SEL_DATA = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LEGACY_BIT = 0;
  localparam int IDX_FILE_BIT = 8;
  localparam int CMD_COMMIT_BIT = 0;
  localparam int STAT_LEGACY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int SEL_W = 16;
  localparam int LEGACY_GPR_W = 32;
  localparam int MANT_W = 64;
  localparam int FP_W = 80;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [6:0] INT_ZERO = 7'h00;
  localparam logic [6:0] INT_PRES_FIRST = 7'h04;
  localparam logic [6:0] INT_PRES_LAST = 7'h07;
  localparam logic [6:0] INT_GPR_FIRST = 7'h08;
  localparam logic [6:0] INT_GPR_LAST = 7'h0f;
  localparam logic [6:0] INT_SEL_DATA_PACK = 7'h10;
  localparam logic [6:0] INT_SEL_CODE_PACK = 7'h11;
  localparam logic [6:0] INT_EXTRA_DESC = 7'h18;
  localparam logic [6:0] INT_DESC_FIRST = 7'h1b;
  localparam logic [6:0] INT_DESC_LAST = 7'h1f;
  localparam logic [6:0] FP_ZERO = 7'h00;
  localparam logic [6:0] FP_ONE = 7'h01;
  localparam logic [6:0] FP_PRES_FIRST = 7'h02;
  localparam logic [6:0] FP_PRES_LAST = 7'h05;
  localparam logic [6:0] FP_LEGACY_FIRST = 7'h08;
  localparam logic [6:0] FP_LEGACY_LAST = 7'h1f;

  // Sign 0, biased exponent 3fff, explicit integer bit set
  localparam logic [79:0] FP_ONE_VAL = 80'h3fff_8000_0000_0000_0000;

  typedef enum {CL_CONST, CL_PRESERVED, CL_LEGACY, CL_SCRATCH} class_type;

  // ----------------------------------------------------------------
  // Convention of each register across legacy execution
  // ----------------------------------------------------------------
  function automatic class_type reg_class(input logic fp, input logic [6:0] i);
    if (!fp) begin
      if (i == INT_ZERO) return CL_CONST;
      if (i >= INT_PRES_FIRST && i <= INT_PRES_LAST) return CL_PRESERVED;
      if (i >= INT_GPR_FIRST && i <= INT_SEL_CODE_PACK) return CL_LEGACY;
      if (i == INT_EXTRA_DESC) return CL_LEGACY;
      if (i >= INT_DESC_FIRST && i <= INT_DESC_LAST) return CL_LEGACY;
      return CL_SCRATCH;
    end
    if (i <= FP_ONE) return CL_CONST;
    if (i >= FP_PRES_FIRST && i <= FP_PRES_LAST) return CL_PRESERVED;
    if (i >= FP_LEGACY_FIRST && i <= FP_LEGACY_LAST) return CL_LEGACY;
    return CL_SCRATCH;
  endfunction

  // Byte-lane merge of a bus write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

endpackage

//--- tb/alias_map_chk.sv
// Purpose: Port checks of the register alias map
// Assumes: Bound to alias_map, one clock
// Notes: Reads answer one cycle after the take
`timescale 1ns/1ps
`default_nettype none
module alias_map_chk
  import alias_map_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic LEGACY_MODE
);
  logic tk;
  logic wr_ctrl;
  assign tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_ctrl = tk && WB_WE_I && WB_ADR_I == A_CTRL;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence rd_s(a);
    tk && !WB_WE_I && WB_ADR_I == a ##1 WB_ACK_O;
  endsequence
  a_ack_after_take: assert property (tk |=> WB_ACK_O) else $error("ack missing");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_has_req: assert property (WB_ACK_O |-> $past(tk)) else $error("stray ack");
  a_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
  a_mode_on_write: assert property (wr_ctrl && WB_SEL_I[0] |=> LEGACY_MODE == $past(WB_DAT_I[0]))
    else $error("mode not written");
  a_mode_held: assert property (!wr_ctrl |=> $stable(LEGACY_MODE)) else $error("mode moved");
  a_cmd_reads_zero: assert property (rd_s(A_CMD) |-> WB_DAT_O == 32'h0) else $error("cmd read");
  a_status_mode: assert property (rd_s(A_STATUS) |-> WB_DAT_O[0] == LEGACY_MODE)
    else $error("status mode");
  a_unmapped_zero: assert property (tk && !WB_WE_I && WB_ADR_I > A_SEL_DATA |=> WB_DAT_O == 32'h0)
    else $error("unmapped read");
endmodule
bind alias_map alias_map_chk chk_u (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .LEGACY_MODE);
`default_nettype wire

//--- tb/alias_map_tb.sv
// Purpose: Self-checking bench of the register alias map
// Assumes: Classic Wishbone master tasks
// Notes: Random values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module alias_map_tb;
  import alias_map_pkg::*;
  localparam logic [63:0] FILL = 64'h0123_4567_89ab_cdef;
  logic clk, rst_n, cyc, stb, we, ack, mode;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] di, dout, r;
  logic [63:0] v [16];
  logic [7:0] t [10] = '{8'h01, 8'h04, 8'h07, 8'h14, 8'h19, 8'h40, 8'h7f, 8'h82, 8'h85, 8'h86};
  int miscompares, samples_checked, cycles;
  alias_map #(.UNDEF_FILL(FILL)) dut_u (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(di),
    .WB_DAT_O(dout), .WB_ACK_O(ack), .LEGACY_MODE(mode));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    di <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(80'(ack), 80'h1);
    r = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idx(input logic fp, input logic [6:0] i);
    wb(1'b1, A_INDEX, {23'h0, fp, 1'b0, i});
  endtask
  task automatic setr(input logic fp, input logic [6:0] i, input logic [79:0] x);
    idx(fp, i);
    wb(1'b1, A_DATA_LO, x[31:0]);
    wb(1'b1, A_DATA_HI, x[63:32]);
    wb(1'b1, A_DATA_EXP, {16'h0, x[79:64]});
    wb(1'b1, A_CMD, 32'h1);
  endtask
  task automatic getr(input logic fp, input logic [6:0] i, input logic [79:0] x);
    logic [79:0] g;
    idx(fp, i);
    wb(1'b0, A_DATA_LO, 32'h0);
    g[31:0] = r;
    wb(1'b0, A_DATA_HI, 32'h0);
    g[63:32] = r;
    wb(1'b0, A_DATA_EXP, 32'h0);
    g[79:64] = r[15:0];
    chk(g, x);
  endtask
  function automatic logic [79:0] after_exit(input logic [7:0] k, input logic [63:0] x);
    if ((!k[7] && k[6:0] >= 4 && k[6:0] <= 7) || (k[7] && k[6:0] >= 2 && k[6:0] <= 5)) begin
      return {16'h0, x};
    end
    return {16'h0, FILL};
  endfunction
  initial begin
    {rst_n, cyc, stb, we, adr, di} = '0;
    sel = 4'hf;
    void'($urandom(32'h5f13));
    foreach (v[k]) v[k] = {$urandom, $urandom};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    getr(1'b1, 7'd1, FP_ONE_VAL);
    setr(1'b0, 7'd0, 80'h1234);
    getr(1'b0, 7'd0, 80'h0);
    $display("constants done");
    for (int k = 0; k < 10; k++) setr(t[k][7], t[k][6:0], {16'h0, v[k]});
    wb(1'b1, A_CTRL, 32'h1);
    chk(80'(mode), 80'h1);
    wb(1'b1, A_CTRL, 32'h0);
    for (int k = 0; k < 10; k++) getr(t[k][7], t[k][6:0], after_exit(t[k], v[k]));
    $display("legacy exit done");
    setr(1'b0, 7'd10, {16'h0, v[10]});
    wb(1'b1, A_CTRL, 32'h1);
    setr(1'b0, 7'd10, {16'h0, v[11]});
    getr(1'b0, 7'd10, {16'h0, v[10][63:32], v[11][31:0]});
    getr(1'b0, 7'd4, 80'h0);
    wb(1'b0, A_STATUS, 32'h0);
    chk(80'(r[1:0]), 80'h3);
    wb(1'b1, A_STATUS, 32'h2);
    wb(1'b0, A_STATUS, 32'h0);
    chk(80'(r[1:0]), 80'h1);
    wb(1'b1, A_IP_LO, v[12][31:0]);
    wb(1'b1, A_IP_HI, v[12][63:32]);
    wb(1'b1, A_CTRL, 32'h0);
    wb(1'b0, A_IP_LO, 32'h0);
    chk(80'(r), 80'(v[12][31:0]));
    wb(1'b0, A_IP_HI, 32'h0);
    chk(80'(r), 80'(v[12][63:32]));
    $display("legacy access done");
    for (int f = 0; f < 8; f++) begin
      wb(1'b1, A_SEL_SLOT, 32'(f));
      wb(1'b1, A_SEL_DATA, 32'(f * 32'h1111 + 1));
    end
    getr(1'b0, 7'd16, 80'h3334_2223_1112_0001);
    getr(1'b0, 7'd17, 80'h7778_6667_5556_4445);
    setr(1'b1, 7'd8, {v[13][15:0], v[14]});
    getr(1'b1, 7'd8, {v[13][15:0], v[14]});
    setr(1'b0, 7'd24, {16'h0, v[15]});
    getr(1'b0, 7'd24, {16'h0, v[15]});
    wb(1'b0, 8'h40, 32'h0);
    chk(80'(r), 80'h0);
    $display("layout done");
    end_of_test();
  end
endmodule
`default_nettype wire
